/* File: verilog/adcsq_ctrl.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ns
//Contract
//RQ1: Mode field: off, single, reserved, repeat
//RQ2: Start in single mode converts selected channel
//RQ3: Start bit self-clears once conversion begins
//RQ4: End stores result, sets done, pulses irq
//RQ5: Repeat mode restarts after every conversion
//RQ6: Mode off aborts, result not stored
//RQ7: Channel codes 0-7 valid, others reserved
//RQ8: Gate bit 1 disables analog inputs
//RQ9: Ladder on during conversion or always
//RQ10: Time field selects documented cycle counts
//RQ11: Software writes bit0 zero, bit4 one
//RQ12: Undefined top bits, unstable low bits read
//RQ13: Reading upper result clears done
//RQ14: Busy tracks conversion, clears on low power
//RQ15: Low power resets controls, blocks writes
//RQ16: Software never restarts during conversion
//RQ17: Channel changed only while idle
//RQ18: Software picks long enough conversion time
//RQ19: Software gates inputs when unused
//RQ20: Result registers reset with flags zero
//RQ21: Result bits nine-two high, one-zero low
//RQ22: Conversion lasts exactly selected cycle count
module adcsq_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power mode
  input wire logic low_power,
  // Analog front end
  input wire logic cmp_high,
  output logic [adcsq_pkg::RES_W-1:0] dac_code,
  output logic [adcsq_pkg::NUM_CHAN-1:0] chan_route,
  output logic inputs_enabled,
  output logic ladder_on,
  output logic sample_hold,
  // Event
  output logic conv_done_irq
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV = 3'b100
  } adcsq_state_t;

  adcsq_state_t state_ff;
  logic [7:0] main_ff;
  logic [7:0] timing_ff;
  logic [7:0] res_high_ff;
  logic [1:0] res_low_ff;
  logic done_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;

  logic wr_en;
  logic rd_en;
  logic [1:0] mode;
  logic [3:0] chan;
  logic start_req;
  logic abort;
  logic conv_end;
  logic timer_run;
  logic sar_clear;
  logic [adcsq_pkg::RES_W-1:0] sar_value;

  function automatic logic hit(input logic [adcsq_pkg::ADDR_W-1:0] a,
                               input logic [adcsq_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_ff;

  assign mode = main_ff[adcsq_pkg::MAIN_MODE_LSB +: 2];
  assign chan = main_ff[adcsq_pkg::MAIN_CHAN_LSB +: 4];

  // Reserved mode 10 behaves as off
  // Low power must not launch a conversion that abort would never see
  assign start_req = main_ff[adcsq_pkg::MAIN_START_BIT] && state_ff == ST_IDLE && !low_power
    && (mode == adcsq_pkg::MODE_SINGLE || mode == adcsq_pkg::MODE_REPEAT); // RQ1 RQ2 RQ5
  assign abort = (mode == adcsq_pkg::MODE_OFF || mode == adcsq_pkg::MODE_RSVD
    || low_power) && state_ff != ST_IDLE; // RQ6

  // Control registers; low power holds them at reset and drops writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      main_ff <= adcsq_pkg::MAIN_RESET;
      timing_ff <= adcsq_pkg::TIM_RESET;
    end else if (low_power) begin
      main_ff <= adcsq_pkg::MAIN_RESET; // RQ15
      timing_ff <= adcsq_pkg::TIM_RESET; // RQ15
    end else begin
      if (start_req) begin
        main_ff[adcsq_pkg::MAIN_START_BIT] <= 1'b0; // RQ3
      end
      if (wr_en && hit(paddr, adcsq_pkg::ADDR_CONV_CONTROL_MAIN)) begin
        main_ff <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, adcsq_pkg::ADDR_CONV_CONTROL_TIMING)) begin
        // Fixed bits are stored as written; software keeps them legal
        timing_ff <= {2'b00, pwdata[5:0]}; // RQ11
      end
    end
  end

  // Sequencer: one sample cycle, then approximation
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            state_ff <= ST_SAMPLE; // RQ2
          end
        end
        ST_SAMPLE: begin
          if (abort) begin
            state_ff <= ST_IDLE;
          end else begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_ff <= ST_IDLE; // RQ6
          end else if (conv_end && mode == adcsq_pkg::MODE_REPEAT) begin
            state_ff <= ST_SAMPLE; // RQ5
          end else if (conv_end) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign sar_clear = state_ff == ST_SAMPLE;

  adcsq_timer #(.CNT_W(adcsq_pkg::CNT_W)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .start(start_req || (conv_end && mode == adcsq_pkg::MODE_REPEAT && !abort)),
    .abort(abort),
    .time_sel(timing_ff[adcsq_pkg::TIM_TIME_LSB +: 3]), // RQ10
    .running(timer_run),
    .done(conv_end)
  );

  adcsq_sar #(.RES_W(adcsq_pkg::RES_W)) u_sar (
    .mclk(mclk),
    .nrst(nrst),
    .clear(sar_clear),
    .step(state_ff == ST_CONV),
    .cmp_high(cmp_high),
    .dac_code(dac_code),
    .value(sar_value)
  );

  // Result, done and irq; a new result wins over a read clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      res_high_ff <= 8'h00; // RQ20
      res_low_ff <= 2'h0;
      done_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= conv_end; // RQ4
      if (low_power) begin
        res_high_ff <= 8'h00;
        res_low_ff <= 2'h0;
        done_ff <= 1'b0;
      end else if (conv_end) begin
        res_high_ff <= sar_value[9:2]; // RQ21
        res_low_ff <= sar_value[1:0]; // RQ21
        done_ff <= 1'b1; // RQ4
      end else if (rd_en && hit(paddr, adcsq_pkg::ADDR_RESULT_HIGH)) begin
        done_ff <= 1'b0; // RQ13
      end
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (hit(paddr, adcsq_pkg::ADDR_RESULT_LOW_STATUS)) begin
        // Low nibble is don't-care to software; reads zero here
        prdata_ff[7:0] <= {res_low_ff, done_ff, timer_run, 4'h0}; // RQ12 RQ14
      end else if (hit(paddr, adcsq_pkg::ADDR_RESULT_HIGH)) begin
        prdata_ff[7:0] <= res_high_ff;
      end else if (hit(paddr, adcsq_pkg::ADDR_CONV_CONTROL_MAIN)) begin
        prdata_ff[7:0] <= main_ff;
      end else if (hit(paddr, adcsq_pkg::ADDR_CONV_CONTROL_TIMING)) begin
        prdata_ff[7:0] <= timing_ff; // RQ12
      end
    end
  end

  // Channel routing, gating and ladder
  always_comb begin
    chan_route = '0;
    if (!chan[3]) begin
      chan_route[chan[2:0]] = 1'b1; // RQ7
    end
  end

  assign inputs_enabled = !main_ff[adcsq_pkg::MAIN_GATE_BIT]; // RQ8
  assign ladder_on = timing_ff[adcsq_pkg::TIM_LADDER_BIT] || timer_run; // RQ9
  assign sample_hold = state_ff == ST_SAMPLE;
  assign conv_done_irq = irq_ff;

  // Checks
  property p_start_clears;
    @(posedge mclk) disable iff (!nrst)
    start_req && !low_power |=> !main_ff[adcsq_pkg::MAIN_START_BIT] || $past(wr_en);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start bit stuck"); // RQ3

  property p_done_irq;
    @(posedge mclk) disable iff (!nrst)
    conv_end && !low_power |=> done_ff && conv_done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done or irq missing"); // RQ4

  property p_repeat;
    @(posedge mclk) disable iff (!nrst)
    conv_end && mode == adcsq_pkg::MODE_REPEAT && !abort |=> timer_run;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat did not restart"); // RQ5

  property p_abort;
    @(posedge mclk) disable iff (!nrst)
    // Low power clears results itself, so only a mode abort must keep them
    abort && !low_power |=> !timer_run && $stable(res_high_ff);
  endproperty
  a_abort: assert property (p_abort) else $error("abort stored result"); // RQ6

  property p_route;
    @(posedge mclk) disable iff (!nrst)
    chan[3] |-> chan_route == '0;
  endproperty
  a_route: assert property (p_route) else $error("reserved channel routed"); // RQ7

  property p_ladder;
    @(posedge mclk) disable iff (!nrst)
    state_ff != ST_IDLE |-> ladder_on;
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder off in conversion"); // RQ9

  property p_time39;
    @(posedge mclk) disable iff (!nrst)
    start_req && timing_ff[3:1] == 3'h0 && !low_power |-> ##39 conv_end;
  endproperty
  a_time39: assert property (p_time39) else $error("conversion length wrong"); // RQ22

  property p_rd_clear;
    @(posedge mclk) disable iff (!nrst)
    rd_en && hit(paddr, adcsq_pkg::ADDR_RESULT_HIGH) && !conv_end |=> !done_ff;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("done not cleared"); // RQ13

  property p_lp;
    @(posedge mclk) disable iff (!nrst)
    low_power |=> main_ff == adcsq_pkg::MAIN_RESET && !timer_run && res_high_ff == 8'h00;
  endproperty
  a_lp: assert property (p_lp) else $error("low power not reset"); // RQ15 RQ14

  property p_busy;
    @(posedge mclk) disable iff (!nrst)
    (state_ff != ST_IDLE) == timer_run;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag out of step"); // RQ14

  property p_irq_pulse;
    @(posedge mclk) disable iff (!nrst)
    conv_done_irq |=> !conv_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle"); // RQ4

  property p_lp_start;
    @(posedge mclk) disable iff (!nrst)
    low_power |-> !start_req;
  endproperty
  a_lp_start: assert property (p_lp_start) else $error("start in low power"); // RQ15

  c_single: cover property (@(posedge mclk) disable iff (!nrst)
    mode == adcsq_pkg::MODE_SINGLE && conv_end);
  c_repeat: cover property (@(posedge mclk) disable iff (!nrst)
    mode == adcsq_pkg::MODE_REPEAT && conv_end ##1 timer_run);
  c_abort: cover property (@(posedge mclk) disable iff (!nrst) abort);
  c_lowpower: cover property (@(posedge mclk) disable iff (!nrst)
    low_power && timer_run);

endmodule : adcsq_ctrl

/* File: verilog/adcsq_pkg.sv */
package adcsq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW_STATUS = 8'h1F;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h20;
  localparam logic [7:0] IDX_CONV_CONTROL_MAIN = 8'h25;
  localparam logic [7:0] IDX_CONV_CONTROL_TIMING = 8'h26;
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_RESULT_LOW_STATUS = {IDX_RESULT_LOW_STATUS, 2'b00};
  localparam logic [9:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_CONV_CONTROL_MAIN = {IDX_CONV_CONTROL_MAIN, 2'b00};
  localparam logic [9:0] ADDR_CONV_CONTROL_TIMING = {IDX_CONV_CONTROL_TIMING, 2'b00};
  // Extra register for sampled-comparator and low-power inputs is not needed

  // Main control fields
  localparam int MAIN_START_BIT = 7;
  localparam int MAIN_MODE_LSB = 5;
  localparam int MAIN_GATE_BIT = 4;
  localparam int MAIN_CHAN_LSB = 0;
  localparam logic [7:0] MAIN_RESET = 8'h10;

  // Timing control fields
  localparam int TIM_LADDER_BIT = 5;
  localparam int TIM_FIXED_ONE_BIT = 4;
  localparam int TIM_TIME_LSB = 1;
  localparam logic [7:0] TIM_RESET = 8'h10;

  // Status fields of the low result register
  localparam int STAT_DONE_BIT = 5;
  localparam int STAT_BUSY_BIT = 4;

  // Operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_RSVD = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // Conversion times in oscillator cycles
  localparam int CONV_CYC_0 = 39;
  localparam int CONV_CYC_2 = 78;
  localparam int CONV_CYC_3 = 156;
  localparam int CONV_CYC_4 = 312;
  localparam int CONV_CYC_5 = 624;
  localparam int CONV_CYC_6 = 1248;
  localparam int CNT_W = 11;

  localparam int RES_W = 10;
  localparam int NUM_CHAN = 8;

endpackage : adcsq_pkg

/* File: verilog/adcsq_timer.sv */
`timescale 1ns/1ns
// Counts the selected conversion length; done pulses on the last cycle.
module adcsq_timer #(
  parameter int CNT_W = adcsq_pkg::CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] time_sel,
  // Status
  output logic running,
  output logic done
);

  if (CNT_W < 11) begin : g_cnt_w_check
    $error("adcsq_timer: CNT_W too small for longest time");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic run_ff;

  function automatic logic [CNT_W-1:0] cycles_of(input logic [2:0] sel);
    case (sel)
      3'h0: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_0);
      3'h2: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_2);
      3'h3: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_3);
      3'h4: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_4);
      3'h5: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_5);
      3'h6: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_6);
      // Reserved codes fall back to the longest time, the safe choice
      default: cycles_of = CNT_W'(adcsq_pkg::CONV_CYC_6);
    endcase
  endfunction : cycles_of

  assign running = run_ff;
  assign done = run_ff && !abort && (cnt_ff == CNT_W'(1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (abort) begin
      run_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (start) begin
      run_ff <= 1'b1;
      cnt_ff <= cycles_of(time_sel); // RQ10 RQ22
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
      if (cnt_ff == CNT_W'(1)) begin
        run_ff <= 1'b0;
      end
    end
  end

endmodule : adcsq_timer

/* File: verilog/adcsq_sar.sv */
`timescale 1ns/1ns
// Successive approximation register: one bit decided per step, MSB first.
module adcsq_sar #(
  parameter int RES_W = adcsq_pkg::RES_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic cmp_high,
  // Ladder code and result
  output logic [RES_W-1:0] dac_code,
  output logic [RES_W-1:0] value
);

  if (RES_W < 2) begin : g_res_w_check
    $error("adcsq_sar: RES_W must be at least 2");
  end

  logic [RES_W-1:0] trial_ff;
  logic [RES_W-1:0] acc_ff;

  assign dac_code = acc_ff | trial_ff;
  assign value = acc_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trial_ff <= '0;
      acc_ff <= '0;
    end else if (clear) begin
      trial_ff <= {1'b1, {(RES_W-1){1'b0}}};
      acc_ff <= '0;
    end else if (step && (trial_ff != '0)) begin
      // Keep the trial bit when the input stays at or above the ladder
      if (cmp_high) begin
        acc_ff <= acc_ff | trial_ff;
      end
      trial_ff <= trial_ff >> 1;
    end
  end

endmodule : adcsq_sar

/* File: tb/adcsq_afe_model.sv */
`timescale 1ns/1ns
// Analog front end: eight channel levels, sample-hold and comparator
module adcsq_afe_model (
  // Clock
  input wire logic mclk,
  // Channel levels, ten bits each
  input wire logic [79:0] vin_bus,
  // Converter side
  input wire logic [9:0] dac_code,
  input wire logic [7:0] chan_route,
  input wire logic sample_hold,
  output logic cmp_high
);
  logic [9:0] sel;
  logic [9:0] held_ff;
  // An unrouted input reads as ground
  always_comb begin
    sel = 10'h000;
    for (int i = 0; i < 8; i++) begin
      if (chan_route[i]) begin
        sel = vin_bus[i*10 +: 10];
      end
    end
  end
  // Tracks while sampling, then holds for the rest of the conversion
  always_ff @(posedge mclk) begin
    if (sample_hold) begin
      held_ff <= sel;
    end
  end
  assign cmp_high = (sample_hold ? sel : held_ff) >= dac_code;
endmodule : adcsq_afe_model

/* File: tb/adc_sequencer_control_test.sv */
`timescale 1ns/1ns
module adc_sequencer_control_test;
  localparam logic [9:0] A_LO = adcsq_pkg::ADDR_RESULT_LOW_STATUS;
  localparam logic [9:0] A_HI = adcsq_pkg::ADDR_RESULT_HIGH;
  localparam logic [9:0] A_MN = adcsq_pkg::ADDR_CONV_CONTROL_MAIN;
  localparam logic [9:0] A_TM = adcsq_pkg::ADDR_CONV_CONTROL_TIMING;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic low_power = 1'b0;
  logic [79:0] vin_bus = 80'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, cmp_high, inputs_enabled, ladder_on, sample_hold, conv_done_irq;
  logic [9:0] dac_code;
  logic [7:0] chan_route;
  logic [2:0] codes [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h7};
  int lens [8] = '{39, 78, 156, 312, 624, 1248, 1248, 1248};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int irq_cyc = 0;
  int irq_cnt = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (conv_done_irq === 1'b1) begin
      irq_cyc <= cyc;
      irq_cnt <= irq_cnt + 1;
    end
  end
  adcsq_ctrl uut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .low_power, .cmp_high, .dac_code, .chan_route, .inputs_enabled,
    .ladder_on, .sample_hold, .conv_done_irq);
  adcsq_afe_model afe (.mclk, .vin_bus, .dac_code, .chan_route, .sample_hold, .cmp_high);
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Called just after a rising edge; returns one edge after the access edge
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      final_report();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wait_irq(input int n);
    int k;
    int c0;
    k = 0;
    c0 = irq_cnt;
    while (irq_cnt < c0 + n && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 3000) begin
      fails++;
      final_report();
    end
  endtask : wait_irq
  task automatic t_reset();
    apb(1'b0, A_MN, 8'h00);
    check(rd, 32'h10);
    apb(1'b0, A_HI, 8'h00);
    check(rd, 32'h0);
    apb(1'b0, A_LO, 8'h00);
    check(rd[7:4], 4'h0);
    apb(1'b0, A_TM, 8'h00);
    check(rd[5:0], 6'h10);
    check(inputs_enabled, 1'b0);
    check(ladder_on, 1'b0);
    apb(1'b0, 10'h3FC, 8'h00);
    check(rd, 32'h0);
    check(pslverr, 1'b0);
  endtask : t_reset
  task automatic t_single(input logic [3:0] c, input logic [2:0] code, input int n);
    int t0;
    logic [9:0] v;
    v = vin_bus[c*10 +: 10];
    apb(1'b1, A_TM, {4'h1, code, 1'b0});
    apb(1'b1, A_MN, {4'h2, c});
    check(inputs_enabled, 1'b1);
    check(chan_route, 8'h01 << c);
    apb(1'b1, A_MN, {4'hA, c});
    t0 = cyc;
    apb(1'b0, A_LO, 8'h00);
    check(rd[4], 1'b1);
    check(ladder_on, 1'b1);
    apb(1'b0, A_MN, 8'h00);
    check(rd[7], 1'b0);
    wait_irq(1);
    check(irq_cyc - t0, n + 1);
    apb(1'b0, A_LO, 8'h00);
    check(rd[7:4], {v[1:0], 2'b10});
    apb(1'b0, A_HI, 8'h00);
    check(rd, v[9:2]);
    apb(1'b0, A_LO, 8'h00);
    check(rd[5], 1'b0);
  endtask : t_single
  task automatic t_repeat();
    int c0;
    logic [9:0] v;
    v = vin_bus[19:10];
    apb(1'b1, A_TM, 8'h1C);
    apb(1'b1, A_MN, 8'hE1);
    wait_irq(1);
    // Second conversion has sampled already; the third sees the new level
    repeat (20) @(posedge mclk);
    vin_bus[19:10] <= ~v;
    wait_irq(1);
    repeat (30) @(posedge mclk);
    apb(1'b1, A_MN, 8'h01);
    apb(1'b0, A_LO, 8'h00);
    check(rd[4], 1'b0);
    c0 = irq_cnt;
    repeat (1300) @(posedge mclk);
    check(irq_cnt, c0);
    apb(1'b0, A_HI, 8'h00);
    check(rd, v[9:2]);
    vin_bus[19:10] <= v;
  endtask : t_repeat
  task automatic t_modes();
    logic [7:0] m [2] = '{8'hC3, 8'h83};
    foreach (m[i]) begin
      apb(1'b1, A_MN, m[i]);
      repeat (3) @(posedge mclk);
      apb(1'b0, A_LO, 8'h00);
      check(rd[4], 1'b0);
    end
    apb(1'b1, A_TM, 8'h30);
    check(ladder_on, 1'b1);
    apb(1'b1, A_MN, 8'h18);
    check(chan_route, 8'h00);
    check(inputs_enabled, 1'b0);
  endtask : t_modes
  task automatic t_lowpwr();
    int c0;
    apb(1'b1, A_TM, 8'h1C);
    apb(1'b1, A_MN, 8'hA2);
    repeat (5) @(posedge mclk);
    low_power <= 1'b1;
    @(posedge mclk);
    apb(1'b0, A_LO, 8'h00);
    check(rd[4], 1'b0);
    apb(1'b1, A_MN, 8'h23);
    apb(1'b0, A_MN, 8'h00);
    check(rd, 32'h10);
    apb(1'b0, A_TM, 8'h00);
    check(rd[5:0], 6'h10);
    check(ladder_on, 1'b0);
    low_power <= 1'b0;
    c0 = irq_cnt;
    repeat (1300) @(posedge mclk);
    check(irq_cnt, c0);
  endtask : t_lowpwr
  initial begin
    for (int i = 0; i < 8; i++) begin
      vin_bus[i*10 +: 10] = 10'h0C7 + 10'(i * 97);
    end
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    for (int i = 0; i < 8; i++) begin
      t_single(4'(i), codes[i], lens[i]);
    end
    t_repeat();
    t_modes();
    t_lowpwr();
    final_report();
  end
endmodule : adc_sequencer_control_test
